// File: hdl/isam_pkg.sv
package isam_pkg;
  localparam int          BYTE_W         = 8;
  localparam int          CNT_W          = 4;
  localparam logic [3:0]  LAST_DATA_BIT  = 4'h8;
  localparam logic [3:0]  ACK_BIT        = 4'h9;
  localparam logic [4:0]  TEN_BIT_PREFIX = 5'h1E;
  localparam logic [7:0]  ADDR_RESET     = 8'h00;
  localparam logic [7:0]  BUFFER_RESET   = 8'h00;

  typedef enum logic [1:0] {PH_IDLE, PH_RECV, PH_WAIT} isam_phase_t;
  typedef enum logic [1:0] {ST_ADDR, ST_ADDR_LO, ST_DATA} isam_stage_t;
endpackage

// File: hdl/isam_line_sync.sv
`timescale 1ns/100ps
`default_nettype none
module isam_line_sync (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic sclPin,
  input  wire logic sdaPin,
  output logic      sclRise,
  output logic      sclFall,
  output logic      sdaLevel,
  output logic      startCond,
  output logic      stopCond
);
  typedef struct packed {
    logic sclMeta;
    logic sclSync;
    logic sclPrev;
    logic sdaMeta;
    logic sdaSync;
    logic sdaPrev;
  } isam_sync_t;

  isam_sync_t r;
  isam_sync_t next_r;

  // ----------------------------------------
  // Two-flop synchronisers and edge history
  // ----------------------------------------
  always_comb begin
    next_r         = r;
    next_r.sclMeta = sclPin;
    next_r.sclSync = r.sclMeta;
    next_r.sclPrev = r.sclSync;
    next_r.sdaMeta = sdaPin;
    next_r.sdaSync = r.sdaMeta;
    next_r.sdaPrev = r.sdaSync;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r <= '1;
    end else begin
      r <= next_r;
    end
  end

  assign sclRise   = r.sclSync & ~r.sclPrev;
  assign sclFall   = ~r.sclSync & r.sclPrev;
  assign sdaLevel  = r.sdaSync;
  assign startCond = r.sclSync & r.sclPrev & r.sdaPrev & ~r.sdaSync;
  assign stopCond  = r.sclSync & r.sclPrev & ~r.sdaPrev & r.sdaSync;
endmodule
`default_nettype wire

// File: hdl/isam_address_match.sv
`timescale 1ns/100ps
`default_nettype none
module isam_address_match (
  input  wire logic                        clock,
  input  wire logic                        srst,
  input  wire logic                        portEnable,
  input  wire logic                        tenBitMode,
  input  wire logic                        sclIn,
  input  wire logic                        sdaIn,
  output logic                             sclOut,
  output logic                             sclOe,
  output logic                             sdaOut,
  output logic                             sdaOe,
  input  wire logic                        addrWrite,
  input  wire logic [isam_pkg::BYTE_W-1:0] addrWriteData,
  input  wire logic                        bufferRead,
  input  wire logic                        irqFlagClear,
  input  wire logic                        overflowClear,
  output logic [isam_pkg::BYTE_W-1:0]      slaveAddress,
  output logic [isam_pkg::BYTE_W-1:0]      receiveBuffer,
  output logic                             bufferFull,
  output logic                             receiveOverflow,
  output logic                             portIrqFlag,
  output logic                             addressUpdate
);
  import isam_pkg::*;

  typedef struct packed {
    isam_phase_t       phase;
    isam_stage_t       stage;
    logic [CNT_W-1:0]  cnt;
    logic [BYTE_W-1:0] shift;
    logic [BYTE_W-1:0] addr;
    logic [BYTE_W-1:0] rxBuf;
    logic              bf;
    logic              ov;
    logic              irq;
    logic              ua;
    logic              uaPend;
    logic              endAfter;
    logic              tenMatched;
    logic              sdaOe;
    logic              sclOe;
  } isam_state_t;

  isam_state_t r;
  isam_state_t next_r;
  logic        sclRise;
  logic        sclFall;
  logic        sdaLevel;
  logic        startCond;
  logic        stopCond;
  logic        active;
  logic        byteDone;
  logic        ninthFall;
  logic        room;
  logic        hiMatch;
  logic        tenHdr;

  // ----------------------------------------
  // Line sampling
  // ----------------------------------------
  isam_line_sync isam_line_sync_i (
    .clock     (clock),
    .srst      (srst),
    .sclPin    (sclIn),
    .sdaPin    (sdaIn),
    .sclRise   (sclRise),
    .sclFall   (sclFall),
    .sdaLevel  (sdaLevel),
    .startCond (startCond),
    .stopCond  (stopCond)
  );

  assign active    = portEnable & ~startCond & ~stopCond & (r.phase == PH_RECV);
  assign byteDone  = active & sclFall & (r.cnt == LAST_DATA_BIT);
  assign ninthFall = active & sclFall & (r.cnt == ACK_BIT);
  assign room      = ~r.bf & ~r.ov;
  assign hiMatch   = r.shift[7:1] == r.addr[7:1];
  assign tenHdr    = r.shift[7:3] == TEN_BIT_PREFIX;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    if (addrWrite) begin
      next_r.addr  = addrWriteData;
      next_r.ua    = 1'b0;
      next_r.sclOe = 1'b1;
    end
    if (bufferRead) begin
      next_r.bf = 1'b0;
    end
    if (irqFlagClear) begin
      next_r.irq = 1'b0;
    end
    if (overflowClear) begin
      next_r.ov = 1'b0;
    end
    if (!portEnable) begin
      next_r.phase = PH_IDLE;
      next_r.sdaOe = 1'b1;
      next_r.sclOe = 1'b1;
    end else if (stopCond) begin
      next_r.phase = PH_IDLE;
      next_r.sdaOe = 1'b1;
    end else if (startCond) begin
      next_r.phase    = PH_RECV;
      next_r.stage    = ST_ADDR;
      next_r.cnt      = '0;
      next_r.uaPend   = 1'b0;
      next_r.endAfter = 1'b0;
      next_r.sdaOe    = 1'b1;
    end else if (r.phase == PH_RECV) begin
      if (sclRise && r.cnt < LAST_DATA_BIT) begin
        next_r.shift = {r.shift[6:0], sdaLevel};
        next_r.cnt   = r.cnt + 4'h1;
      end else if (sclRise && r.cnt == LAST_DATA_BIT) begin
        next_r.cnt = ACK_BIT;
      end
      if (byteDone) begin
        case (r.stage)
          ST_ADDR: begin
            if (!hiMatch) begin
              next_r.phase = PH_WAIT;
            end else if (tenBitMode && !(tenHdr && !r.shift[0])
                         && !(tenHdr && r.shift[0] && r.tenMatched)) begin
              next_r.phase = PH_WAIT;
            end else begin
              if (room) begin
                next_r.rxBuf = r.shift;
                next_r.bf    = 1'b1;
                next_r.sdaOe = 1'b0;
              end
              if (tenBitMode && !r.shift[0]) begin
                next_r.uaPend     = 1'b1;
                next_r.stage      = ST_ADDR_LO;
                next_r.tenMatched = 1'b0;
              end else if (r.shift[0]) begin
                next_r.endAfter = 1'b1;
              end else begin
                next_r.stage = ST_DATA;
              end
            end
          end
          ST_ADDR_LO: begin
            if (r.shift != r.addr) begin
              next_r.phase = PH_WAIT;
            end else begin
              if (room) begin
                next_r.rxBuf = r.shift;
                next_r.bf    = 1'b1;
                next_r.sdaOe = 1'b0;
              end
              next_r.uaPend     = 1'b1;
              next_r.tenMatched = 1'b1;
              next_r.stage      = ST_DATA;
            end
          end
          default: begin
            if (room) begin
              next_r.rxBuf = r.shift;
              next_r.bf    = 1'b1;
              next_r.sdaOe = 1'b0;
            end else if (r.bf) begin
              next_r.ov = 1'b1;
            end
          end
        endcase
      end
      if (ninthFall) begin
        next_r.sdaOe  = 1'b1;
        next_r.irq    = 1'b1;
        next_r.cnt    = '0;
        next_r.uaPend = 1'b0;
        if (r.uaPend) begin
          next_r.ua    = 1'b1;
          next_r.sclOe = 1'b0;
        end
        if (r.endAfter) begin
          next_r.phase = PH_WAIT;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r            <= '0;
      r.phase      <= PH_IDLE;
      r.stage      <= ST_ADDR;
      r.addr       <= ADDR_RESET;
      r.rxBuf      <= BUFFER_RESET;
      r.sdaOe      <= 1'b1;
      r.sclOe      <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sclOut          = 1'b0;
  assign sdaOut          = 1'b0;
  assign sclOe           = r.sclOe;
  assign sdaOe           = r.sdaOe;
  assign slaveAddress    = r.addr;
  assign receiveBuffer   = r.rxBuf;
  assign bufferFull      = r.bf;
  assign receiveOverflow = r.ov;
  assign portIrqFlag     = r.irq;
  assign addressUpdate   = r.ua;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence sAccept;
    byteDone && room && r.stage == ST_DATA;
  endsequence

  sequence sAckHeld;
    !sdaOe && bufferFull;
  endsequence

  a_ack_on_room: assert property (@(posedge clock) disable iff (srst)
    sAccept |=> sAckHeld)
    else $error("data byte with room not acknowledged");

  a_buffer_load: assert property (@(posedge clock) disable iff (srst)
    sAccept |=> receiveBuffer == $past(r.shift))
    else $error("receive buffer not loaded from shift register");

  a_no_ack_full: assert property (@(posedge clock) disable iff (srst)
    byteDone && !room |=> sdaOe && $stable(receiveBuffer))
    else $error("byte taken while buffer full or overflowed");

  a_overflow_set: assert property (@(posedge clock) disable iff (srst)
    byteDone && r.bf && r.stage == ST_DATA |=> receiveOverflow)
    else $error("overflow not flagged");

  a_irq_ninth: assert property (@(posedge clock) disable iff (srst)
    ninthFall |=> portIrqFlag && sdaOe)
    else $error("interrupt flag not set at ninth fall");

  a_update_hold: assert property (@(posedge clock) disable iff (srst)
    ninthFall && r.uaPend |=> addressUpdate && !sclOe)
    else $error("address update not raised with clock hold");

  a_addr_release: assert property (@(posedge clock) disable iff (srst)
    addrWrite && !ninthFall |=> !addressUpdate && sclOe
      && slaveAddress == $past(addrWriteData))
    else $error("address write did not release clock");

  a_read_clears: assert property (@(posedge clock) disable iff (srst)
    bufferRead && !byteDone |=> !bufferFull)
    else $error("buffer read left full flag set");

  a_bit_sample: assert property (@(posedge clock) disable iff (srst)
    active && sclRise && r.cnt < LAST_DATA_BIT |=> r.shift[0] == $past(sdaLevel))
    else $error("bit not sampled on rising clock");

  a_no_match: assert property (@(posedge clock) disable iff (srst)
    byteDone && r.stage == ST_ADDR && !hiMatch
      |=> r.phase == PH_WAIT && sdaOe && !$rose(bufferFull))
    else $error("unmatched address disturbed the port");

  a_start_restart: assert property (@(posedge clock) disable iff (srst)
    portEnable && startCond |=> r.phase == PH_RECV && r.cnt == '0)
    else $error("start condition did not restart reception");
endmodule
`default_nettype wire

// File: tb/isam_bus_master.sv
`timescale 1ns/100ps
`default_nettype none
module isam_bus_master (
  input  wire logic sclWire,
  input  wire logic sdaWire,
  output var logic  sclDrive,
  output var logic  sdaDrive
);
  localparam int HALF = 80;

  initial begin
    sclDrive = 1'b1;
    sdaDrive = 1'b1;
  end

  // Release SCL, wait while the slave stretches it
  task automatic raiseScl();
    int n;
    n = 0;
    sclDrive = 1'b1;
    while (sclWire !== 1'b1 && n < 500) begin
      #20;
      n++;
    end
  endtask

  // One SCL pulse; data changes only while SCL is low
  task automatic bitCycle(input logic d, output logic s);
    #20;
    sdaDrive = d;
    #(HALF - 20);
    raiseScl();
    #HALF;
    s = sdaWire;
    sclDrive = 1'b0;
  endtask

  // Start or repeated start: SDA falls while SCL is high
  task automatic sendStart();
    #20;
    sdaDrive = 1'b1;
    #(2 * HALF);
    raiseScl();
    #HALF;
    sdaDrive = 1'b0;
    #HALF;
    sclDrive = 1'b0;
  endtask

  task automatic sendStop();
    #20;
    sdaDrive = 1'b0;
    #(HALF - 20);
    raiseScl();
    #HALF;
    sdaDrive = 1'b1;
    #HALF;
  endtask

  // Eight bits MSB first, then the acknowledge clock
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(b[i], s);
    end
    bitCycle(1'b1, s);
    ack = ~s;
  endtask
endmodule
`default_nettype wire

// File: tb/test_isam_address_match.sv
`timescale 1ns/100ps
`default_nettype none
module test_isam_address_match;
  import isam_pkg::*;
  logic              clock, srst, portEnable, tenBitMode;
  logic              addrWrite, bufferRead, irqFlagClear, overflowClear;
  logic [BYTE_W-1:0] addrWriteData, slaveAddress, receiveBuffer;
  logic              sclOut, sclOe, sdaOut, sdaOe, sclIn, sdaIn;
  logic              bufferFull, receiveOverflow, portIrqFlag;
  logic              addressUpdate, sclDrive, sdaDrive, ack;
  logic [6:0]        st;
  int                n_mismatch, n_compared;

  // Open-drain wires with pull-ups
  assign sclIn = sclDrive & (sclOe | sclOut);
  assign sdaIn = sdaDrive & (sdaOe | sdaOut);
  assign st = {ack, bufferFull, receiveOverflow, portIrqFlag,
               addressUpdate, sclOe, sdaOe};

  isam_address_match isam_address_match_i (
    .clock(clock), .srst(srst), .portEnable(portEnable),
    .tenBitMode(tenBitMode), .sclIn(sclIn), .sdaIn(sdaIn),
    .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrWrite(addrWrite), .addrWriteData(addrWriteData),
    .bufferRead(bufferRead), .irqFlagClear(irqFlagClear),
    .overflowClear(overflowClear), .slaveAddress(slaveAddress),
    .receiveBuffer(receiveBuffer), .bufferFull(bufferFull),
    .receiveOverflow(receiveOverflow), .portIrqFlag(portIrqFlag),
    .addressUpdate(addressUpdate));

  isam_bus_master isam_bus_master_i (
    .sclWire(sclIn), .sdaWire(sdaIn),
    .sclDrive(sclDrive), .sdaDrive(sdaDrive));

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: byte %h not %h", $time, got, exp);
    end
  endtask

  // Status: ack, full, overflow, irq, update, sclOe, sdaOe
  task automatic chkSt(input logic [6:0] exp);
    n_compared++;
    if (st !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: status %b not %b", $time, st, exp);
    end
  endtask

  // Strobes: addrWrite, bufferRead, irqFlagClear, overflowClear
  task automatic cpu(input logic [3:0] s, input logic [7:0] d);
    {addrWrite, bufferRead, irqFlagClear, overflowClear} = s;
    addrWriteData = d;
    @(posedge clock);
    #1;
    {addrWrite, bufferRead, irqFlagClear, overflowClear} = 4'h0;
    @(posedge clock);
    #1;
  endtask

  task automatic xfer(input logic [7:0] b);
    isam_bus_master_i.sendByte(b, ack);
    repeat (6) @(posedge clock);
    #1;
  endtask

  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    {srst, portEnable, tenBitMode, ack} = 4'h8;
    {addrWrite, bufferRead, irqFlagClear, overflowClear} = 4'h0;
    addrWriteData = 8'h00;
    repeat (4) @(posedge clock);
    #1;
    srst = 1'b0;
    portEnable = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk8(slaveAddress, ADDR_RESET);
    chk8(receiveBuffer, BUFFER_RESET);
    chk8({6'h00, sclOut, sdaOut}, 8'h00);
    chkSt(7'h03);
    $display("test reset done");
    cpu(4'h8, 8'hA4);
    chk8(slaveAddress, 8'hA4);
    isam_bus_master_i.sendStart();
    xfer(8'hA4);
    chk8(receiveBuffer, 8'hA4);
    chkSt(7'h6B);
    cpu(4'h6, 8'h00);
    chkSt(7'h43);
    xfer(8'h3C);
    chk8(receiveBuffer, 8'h3C);
    chkSt(7'h6B);
    cpu(4'h2, 8'h00);
    xfer(8'h5A);
    chk8(receiveBuffer, 8'h3C);
    chkSt(7'h3B);
    cpu(4'h6, 8'h00);
    chkSt(7'h13);
    xfer(8'h22);
    chk8(receiveBuffer, 8'h3C);
    chkSt(7'h1B);
    cpu(4'h3, 8'h00);
    chkSt(7'h1B & 7'h43);
    isam_bus_master_i.sendStop();
    $display("test seven-bit done");
    isam_bus_master_i.sendStart();
    xfer(8'h50);
    chkSt(7'h03);
    xfer(8'h77);
    chk8(receiveBuffer, 8'h3C);
    chkSt(7'h03);
    isam_bus_master_i.sendStop();
    $display("test mismatch done");
    tenBitMode = 1'b1;
    cpu(4'h8, 8'hF2);
    isam_bus_master_i.sendStart();
    xfer(8'hF2);
    chk8(receiveBuffer, 8'hF2);
    chkSt(7'h6D);
    cpu(4'h8, 8'h5B);
    chk8(slaveAddress, 8'h5B);
    chkSt(7'h6B);
    cpu(4'h6, 8'h00);
    chkSt(7'h43);
    xfer(8'h5B);
    chk8(receiveBuffer, 8'h5B);
    chkSt(7'h6D);
    cpu(4'h8, 8'hF2);
    chkSt(7'h6B);
    cpu(4'h6, 8'h00);
    isam_bus_master_i.sendStart();
    xfer(8'hF3);
    chk8(receiveBuffer, 8'hF3);
    chkSt(7'h6B);
    cpu(4'h6, 8'h00);
    chkSt(7'h43);
    isam_bus_master_i.sendStop();
    $display("test ten-bit done");
    isam_bus_master_i.sendStart();
    xfer(8'hF2);
    chkSt(7'h6D);
    portEnable = 1'b0;
    @(posedge clock);
    #1;
    portEnable = 1'b1;
    @(posedge clock);
    #1;
    chkSt(7'h6F);
    xfer(8'h11);
    chk8(receiveBuffer, 8'hF2);
    chkSt(7'h2F);
    isam_bus_master_i.sendStop();
    $display("test disable done");
    finish_test();
  end
endmodule
`default_nettype wire
